/* File: code_cfg_if.sv */
`timescale 1ns/1ps
interface code_cfg_if;
    import mon_cfg_pkg::*;
    logic [1:0] decode_sel;
    logic [7:0] code_pins;
    logic [7:0] code_value;
    code_level_t code_level;
    logic code_in_range;
    modport src (output decode_sel, output code_pins, input code_value, input code_level, input code_in_range);
    modport dst (input decode_sel, input code_pins, output code_value, output code_level, output code_in_range);
endinterface : code_cfg_if

/* File: code_decode.sv */
`timescale 1ns/1ps
`include "mon_cfg_consts.svh"
module code_decode
    import mon_cfg_pkg::*;
(
    input wire logic core_clk, // System clock
    input wire logic rst_n, // Async reset
    code_cfg_if.dst cfg // Decode select in, results out
);

    logic [7:0] value_reg;
    logic [7:0] value_next;
    code_level_t level_reg;
    code_level_t level_next;
    logic in_range_reg;
    logic in_range_next;
    logic [9:0] scaled;
    logic [9:0] level_wide;
    code_level_t floor_lvl;

    always_comb begin
        value_next = 8'h00;
        scaled = 10'h000;
        floor_lvl = `LVL_MIN_FINE;
        case (cfg.decode_sel)
            `MODE_SIX: begin
                value_next = {2'h0, cfg.code_pins[5:0]};
                scaled = {1'b0, value_next, 1'b0};
                floor_lvl = `LVL_MIN_SIX;
            end
            `MODE_SEVEN_EXT: begin
                value_next = {1'b0, cfg.code_pins[6:0]};
                scaled = {2'h0, value_next};
            end
            `MODE_SEVEN_LOW: begin
                value_next = {1'b0, cfg.code_pins[6:0]};
                scaled = {2'h0, value_next};
            end
            `MODE_SEVEN_HIGH: begin
                value_next = {cfg.code_pins[7:1], 1'b0};
                scaled = {2'h0, value_next};
                floor_lvl = `LVL_MIN_WIDE;
            end
            default: begin
                value_next = 8'h00;
            end
        endcase
        // Code counts down from the top of the range; never underflows
        level_wide = `LVL_TOP - scaled;
        level_next = level_wide[8:0];
        in_range_next = (level_wide >= {1'b0, floor_lvl});
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            value_reg <= 8'h00;
            level_reg <= 9'h000;
            in_range_reg <= 1'b0;
        end else begin
            value_reg <= value_next;
            level_reg <= level_next;
            in_range_reg <= in_range_next;
        end
    end

    assign cfg.code_value = value_reg;
    assign cfg.code_level = level_reg;
    assign cfg.code_in_range = in_range_reg;

endmodule : code_decode

/* File: mon_cfg_consts.svh */
`ifndef MON_CFG_CONSTS_SVH
`define MON_CFG_CONSTS_SVH

// Register offsets on the byte register port
`define ADDR_CTRL_TWO 8'hBD
`define ADDR_THR_SEL 8'hBE

// Reset values
`define CTRL_TWO_RESET 8'h00
`define THR_SEL_RESET 8'h00

// Bit 1 of the threshold register is reserved and reads as zero
`define THR_SEL_WR_MASK 8'hFD

// Decode select codes
`define MODE_SIX 2'h0
`define MODE_SEVEN_EXT 2'h1
`define MODE_SEVEN_LOW 2'h2
`define MODE_SEVEN_HIGH 2'h3

// Voltage levels in 6.25 mV units
`define LVL_TOP 10'h100
`define LVL_MIN_SIX 9'h086
`define LVL_MIN_FINE 9'h085
`define LVL_MIN_WIDE 9'h006

// Tachometer limits
`define NUM_TACH 4
`define TACH_NO_LIMIT 14'h3FFF

`endif

/* File: mon_cfg_pkg.sv */
package mon_cfg_pkg;

    typedef struct packed {
        logic [1:0] decode_sel;
        logic zone34_half_degree_select;
        logic zone12_half_degree_select;
        logic [3:0] tach_enhanced_enable;
    } ctrl_two_s;

    typedef struct packed {
        logic [3:0] pin_low_threshold;
        logic input9_low_threshold;
        logic input8_low_threshold;
        logic reserved;
        logic cpu_code_pins_low_threshold;
    } thr_sel_s;

    typedef logic [13:0] tach_word_t;
    typedef logic [8:0] code_level_t;

endpackage : mon_cfg_pkg

/* File: mon_cfg_regs.sv */
`timescale 1ns/1ps
`include "mon_cfg_consts.svh"
module mon_cfg_regs
    import mon_cfg_pkg::*;
(
    input wire logic core_clk, // System clock, 100 MHz
    input wire logic rst_n, // Async reset
    input wire logic [7:0] reg_addr, // Register offset
    input wire logic reg_wr_en, // Write strobe
    input wire logic [7:0] reg_wr_data, // Write data
    input wire logic reg_rd_en, // Read strobe
    output logic reg_wr_hit, // Write hits a register
    output logic [7:0] reg_rd_data, // Read data
    output logic reg_rd_valid, // Read data valid
    output logic reg_rd_hit, // Read hit a register
    input wire logic cycle_start, // Measurement cycle boundary
    output logic settings_pending, // Written, not yet applied
    output logic tach1_enhanced_enable, // Tach 1 enhanced mode
    output logic tach2_enhanced_enable, // Tach 2 enhanced mode
    output logic tach3_enhanced_enable, // Tach 3 enhanced mode
    output logic tach4_enhanced_enable, // Tach 4 enhanced mode
    output logic zone12_half_degree_select, // Tables 1/2 at half degree
    output logic zone34_half_degree_select, // Tables 3/4 at half degree
    output logic [1:0] voltage_code_decode_select, // Active decode select
    output logic cpu_code_pins_low_threshold, // Code pins low thresholds
    output logic input8_low_threshold, // Input 8 low thresholds
    output logic input9_low_threshold, // Input 9 low thresholds
    output logic pin4_low_threshold, // Pin 4 low thresholds
    output logic pin5_low_threshold, // Pin 5 low thresholds
    output logic pin6_low_threshold, // Pin 6 low thresholds
    output logic pin7_low_threshold, // Pin 7 low thresholds
    input wire logic [7:0] cpu_code_pins, // Processor code inputs
    output logic [7:0] code_value, // Decoded code value
    output code_level_t code_level, // Level in 6.25 mV units
    output logic code_in_range, // Level inside mode range
    input wire tach_word_t tach_count [`NUM_TACH], // Tach readings
    input wire tach_word_t tach_limit [`NUM_TACH], // Tach limits
    input wire logic [`NUM_TACH-1:0] tach_done, // Reading valid pulses
    input wire logic [`NUM_TACH-1:0] tach_err_clear, // Error clear pulses
    output logic [`NUM_TACH-1:0] tach_err // Sticky tach errors
);

    // Stored, software-visible values
    ctrl_two_s ctrl_two_reg;
    ctrl_two_s ctrl_two_next;
    thr_sel_s thr_sel_reg;
    thr_sel_s thr_sel_next;
    logic pending_reg;
    logic pending_next;

    // Copies in force for the running cycle
    ctrl_two_s ctrl_act_reg;
    ctrl_two_s ctrl_act_next;
    thr_sel_s thr_act_reg;
    thr_sel_s thr_act_next;

    // Registered pin-side controls
    logic [3:0] tach_en_reg;
    logic [3:0] tach_en_next;
    logic z12_reg;
    logic z12_next;
    logic z34_reg;
    logic z34_next;
    logic [1:0] decode_reg;
    logic [1:0] decode_next;
    logic cpu_thr_reg;
    logic cpu_thr_next;
    logic in8_thr_reg;
    logic in8_thr_next;
    logic in9_thr_reg;
    logic in9_thr_next;
    logic [3:0] pin_thr_reg;
    logic [3:0] pin_thr_next;

    // Read port
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;
    logic rd_valid_reg;
    logic rd_valid_next;
    logic rd_hit_reg;
    logic rd_hit_next;

    logic addr_mapped;
    logic legacy_mode;

    code_cfg_if code_bus ();

    assign addr_mapped = (reg_addr == `ADDR_CTRL_TWO) || (reg_addr == `ADDR_THR_SEL);
    assign reg_wr_hit = reg_wr_en & addr_mapped;

    // Register writes
    always_comb begin
        ctrl_two_next = ctrl_two_reg;
        thr_sel_next = thr_sel_reg;
        // A write in the boundary cycle is not applied yet, so it stays pending
        pending_next = pending_reg & ~cycle_start;
        if (reg_wr_en) begin
            case (reg_addr)
                `ADDR_CTRL_TWO: begin
                    ctrl_two_next = ctrl_two_s'(reg_wr_data);
                    pending_next = 1'b1;
                end
                `ADDR_THR_SEL: begin
                    thr_sel_next = thr_sel_s'(reg_wr_data & `THR_SEL_WR_MASK);
                    pending_next = 1'b1;
                end
                default: begin
                    pending_next = pending_next;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_two_reg <= ctrl_two_s'(`CTRL_TWO_RESET);
            thr_sel_reg <= thr_sel_s'(`THR_SEL_RESET);
            pending_reg <= 1'b0;
        end else begin
            ctrl_two_reg <= ctrl_two_next;
            thr_sel_reg <= thr_sel_next;
            pending_reg <= pending_next;
        end
    end

    // Settings change only at a cycle boundary so no measurement mixes two setups
    always_comb begin
        ctrl_act_next = ctrl_act_reg;
        thr_act_next = thr_act_reg;
        if (cycle_start) begin
            ctrl_act_next = ctrl_two_reg;
            thr_act_next = thr_sel_reg;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_act_reg <= ctrl_two_s'(`CTRL_TWO_RESET);
            thr_act_reg <= thr_sel_s'(`THR_SEL_RESET);
        end else begin
            ctrl_act_reg <= ctrl_act_next;
            thr_act_reg <= thr_act_next;
        end
    end

    assign legacy_mode = (ctrl_act_reg.decode_sel == `MODE_SIX);

    // Pin-side controls from the copies in force
    always_comb begin
        // Enhanced mode with a 22.5 kHz PWM is the host's to avoid, not checked here
        tach_en_next = ctrl_act_reg.tach_enhanced_enable;
        z12_next = ctrl_act_reg.zone12_half_degree_select;
        z34_next = ctrl_act_reg.zone34_half_degree_select;
        decode_next = ctrl_act_reg.decode_sel;
        cpu_thr_next = thr_act_reg.cpu_code_pins_low_threshold;
        in8_thr_next = thr_act_reg.input8_low_threshold & legacy_mode;
        in9_thr_next = thr_act_reg.input9_low_threshold & legacy_mode;
        pin_thr_next = thr_act_reg.pin_low_threshold;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tach_en_reg <= 4'h0;
            z12_reg <= 1'b0;
            z34_reg <= 1'b0;
            decode_reg <= `MODE_SIX;
            cpu_thr_reg <= 1'b0;
            in8_thr_reg <= 1'b0;
            in9_thr_reg <= 1'b0;
            pin_thr_reg <= 4'h0;
        end else begin
            tach_en_reg <= tach_en_next;
            z12_reg <= z12_next;
            z34_reg <= z34_next;
            decode_reg <= decode_next;
            cpu_thr_reg <= cpu_thr_next;
            in8_thr_reg <= in8_thr_next;
            in9_thr_reg <= in9_thr_next;
            pin_thr_reg <= pin_thr_next;
        end
    end

    // Readback shows the stored value, even before it is applied
    always_comb begin
        rd_data_next = 8'h00;
        rd_hit_next = 1'b0;
        rd_valid_next = reg_rd_en;
        if (reg_rd_en) begin
            case (reg_addr)
                `ADDR_CTRL_TWO: begin
                    rd_data_next = ctrl_two_reg;
                    rd_hit_next = 1'b1;
                end
                `ADDR_THR_SEL: begin
                    rd_data_next = thr_sel_reg;
                    rd_hit_next = 1'b1;
                end
                default: begin
                    rd_data_next = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_reg <= 8'h00;
            rd_valid_reg <= 1'b0;
            rd_hit_reg <= 1'b0;
        end else begin
            rd_data_reg <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
            rd_hit_reg <= rd_hit_next;
        end
    end

    // The decoder sees the same select as the pins, one cycle earlier
    assign code_bus.decode_sel = ctrl_act_reg.decode_sel;
    assign code_bus.code_pins = cpu_code_pins;

    code_decode u_code_decode (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .cfg(code_bus)
    );

    tach_limit_check u_tach_limit_check (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .tach_count(tach_count),
        .tach_limit(tach_limit),
        .tach_done(tach_done),
        .err_clear(tach_err_clear),
        .tach_err(tach_err)
    );

    assign reg_rd_data = rd_data_reg;
    assign reg_rd_valid = rd_valid_reg;
    assign reg_rd_hit = rd_hit_reg;
    assign settings_pending = pending_reg;
    assign tach1_enhanced_enable = tach_en_reg[0];
    assign tach2_enhanced_enable = tach_en_reg[1];
    assign tach3_enhanced_enable = tach_en_reg[2];
    assign tach4_enhanced_enable = tach_en_reg[3];
    assign zone12_half_degree_select = z12_reg;
    assign zone34_half_degree_select = z34_reg;
    assign voltage_code_decode_select = decode_reg;
    assign cpu_code_pins_low_threshold = cpu_thr_reg;
    assign input8_low_threshold = in8_thr_reg;
    assign input9_low_threshold = in9_thr_reg;
    assign pin4_low_threshold = pin_thr_reg[0];
    assign pin5_low_threshold = pin_thr_reg[1];
    assign pin6_low_threshold = pin_thr_reg[2];
    assign pin7_low_threshold = pin_thr_reg[3];
    assign code_value = code_bus.code_value;
    assign code_level = code_bus.code_level;
    assign code_in_range = code_bus.code_in_range;

endmodule : mon_cfg_regs

/* File: mon_cfg_regs_assertions.sv */
`timescale 1ns/1ps
`include "mon_cfg_consts.svh"
module mon_cfg_regs_assertions
    import mon_cfg_pkg::*;
(
    input wire logic core_clk, // Clock
    input wire logic rst_n, // Async reset
    input wire logic [7:0] reg_addr, // Offset
    input wire logic reg_wr_en, // Write strobe
    input wire logic reg_rd_en, // Read strobe
    input wire logic reg_wr_hit, // Write hit
    input wire logic [7:0] reg_rd_data, // Read data
    input wire logic reg_rd_valid, // Read valid
    input wire logic reg_rd_hit, // Read hit
    input wire logic cycle_start, // Apply pulse
    input wire logic settings_pending, // Pending
    input wire logic [1:0] voltage_code_decode_select, // Active decode
    input wire logic input8_low_threshold, // Input 8
    input wire logic input9_low_threshold, // Input 9
    input wire logic [7:0] cpu_code_pins, // Code pins
    input wire logic [7:0] code_value, // Decoded code
    input wire tach_word_t tach_count [`NUM_TACH], // Readings
    input wire tach_word_t tach_limit [`NUM_TACH], // Limits
    input wire logic [`NUM_TACH-1:0] tach_done, // Valid pulses
    input wire logic [`NUM_TACH-1:0] tach_err // Errors
);
    logic mapped;
    logic over0;
    logic [7:0] pins_q;
    assign mapped = (reg_addr == `ADDR_CTRL_TWO) || (reg_addr == `ADDR_THR_SEL);
    assign over0 = tach_done[0] && (tach_count[0] > tach_limit[0]) && (tach_limit[0] != `TACH_NO_LIMIT);
    // Pins as seen one edge earlier, the decode latency
    always_ff @(posedge core_clk) begin
        pins_q <= cpu_code_pins;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_read_answer: assert property (reg_rd_en |=> reg_rd_valid && reg_rd_hit == $past(mapped))
        else $error("read answer missing or hit wrong");
    a_idle_read: assert property (!reg_rd_en |=> !reg_rd_valid && reg_rd_data == 8'h00)
        else $error("read data without a read");
    a_unmapped_zero: assert property (reg_rd_en && !mapped |=> reg_rd_data == 8'h00 && !reg_rd_hit)
        else $error("unmapped read not zero");
    a_reserved_zero: assert property (reg_rd_en && reg_addr == `ADDR_THR_SEL |=> !reg_rd_data[1])
        else $error("reserved bit reads one");
    a_write_hit: assert property (reg_wr_hit == (reg_wr_en && mapped))
        else $error("write hit wrong");
    a_pending_set: assert property (reg_wr_hit |=> settings_pending)
        else $error("pending not set");
    a_pending_clear: assert property (cycle_start && !reg_wr_hit |=> !settings_pending)
        else $error("pending not cleared");
    a_input_gate: assert property (voltage_code_decode_select != 2'h0
        |-> !input8_low_threshold && !input9_low_threshold)
        else $error("input 8/9 threshold outside mode 00");
    a_mode_six: assert property ($past(rst_n) && voltage_code_decode_select == 2'h0
        && $stable(voltage_code_decode_select) |-> code_value == {2'b00, pins_q[5:0]})
        else $error("mode 00 decode wrong");
    a_mode_seven: assert property ($past(rst_n) && (^voltage_code_decode_select)
        && $stable(voltage_code_decode_select) |-> code_value == {1'b0, pins_q[6:0]})
        else $error("mode 01/10 decode wrong");
    a_mode_wide: assert property ($past(rst_n) && voltage_code_decode_select == 2'h3
        && $stable(voltage_code_decode_select) |-> code_value == {pins_q[7:1], 1'b0})
        else $error("mode 11 decode wrong");
    a_tach_set: assert property (over0 |=> tach_err[0])
        else $error("tach error not raised");
    a_tach_quiet: assert property (!tach_err[0] && !over0 |=> !tach_err[0])
        else $error("tach error without cause");
endmodule : mon_cfg_regs_assertions

bind mon_cfg_regs mon_cfg_regs_assertions u_chk (.core_clk, .rst_n, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wr_hit,
    .reg_rd_data, .reg_rd_valid, .reg_rd_hit, .cycle_start, .settings_pending, .voltage_code_decode_select,
    .input8_low_threshold, .input9_low_threshold, .cpu_code_pins, .code_value, .tach_count, .tach_limit,
    .tach_done, .tach_err);

/* File: tach_limit_check.sv */
`timescale 1ns/1ps
`include "mon_cfg_consts.svh"
module tach_limit_check
    import mon_cfg_pkg::*;
(
    input wire logic core_clk, // System clock
    input wire logic rst_n, // Async reset
    input wire tach_word_t tach_count [`NUM_TACH], // Latest readings
    input wire tach_word_t tach_limit [`NUM_TACH], // Programmed limits
    input wire logic [`NUM_TACH-1:0] tach_done, // Reading valid pulses
    input wire logic [`NUM_TACH-1:0] err_clear, // Clear pulses
    output logic [`NUM_TACH-1:0] tach_err // Sticky error flags
);

    logic [`NUM_TACH-1:0] err_reg;
    logic err_next [`NUM_TACH];

    genvar ch;
    generate
        for (ch = 0; ch < `NUM_TACH; ch++) begin : g_ch
            always_comb begin
                err_next[ch] = err_reg[ch] & ~err_clear[ch];
                // A new error wins over a clear in the same cycle
                if (tach_done[ch] && (tach_limit[ch] != `TACH_NO_LIMIT) && (tach_count[ch] > tach_limit[ch])) begin
                    err_next[ch] = 1'b1;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            err_reg <= '0;
        end else begin
            for (int k = 0; k < `NUM_TACH; k++) begin
                err_reg[k] <= err_next[k];
            end
        end
    end

    assign tach_err = err_reg;

endmodule : tach_limit_check

/* File: vid_mode_tach_config_regs_test.sv */
`timescale 1ns/1ps
`include "mon_cfg_consts.svh"
module vid_mode_tach_config_regs_test
    import mon_cfg_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wr_data = 8'h00;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic cycle_start = 1'b0;
    logic [7:0] cpu_code_pins = 8'h00;
    tach_word_t tach_count [`NUM_TACH] = '{default: 14'h0000};
    tach_word_t tach_limit [`NUM_TACH] = '{default: 14'h0000};
    logic [3:0] tach_done = 4'h0;
    logic [3:0] tach_err_clear = 4'h0;
    logic reg_wr_hit, reg_rd_valid, reg_rd_hit, settings_pending, code_in_range;
    logic [7:0] reg_rd_data, code_value;
    logic tach1_enhanced_enable, tach2_enhanced_enable, tach3_enhanced_enable, tach4_enhanced_enable;
    logic zone12_half_degree_select, zone34_half_degree_select, cpu_code_pins_low_threshold;
    logic input8_low_threshold, input9_low_threshold;
    logic pin4_low_threshold, pin5_low_threshold, pin6_low_threshold, pin7_low_threshold;
    logic [1:0] voltage_code_decode_select;
    code_level_t code_level;
    logic [3:0] tach_err;
    int errors = 0;
    int comparisons = 0;
    logic [31:0] seed = 32'h7B9D26D2;
    logic [7:0] m_ctrl = 8'h00, m_thr = 8'h00, a_ctrl = 8'h00, a_thr = 8'h00;
    logic m_pend = 1'b0;
    logic [3:0] m_err = 4'h0;
    wire [7:0] ctrl_out = {voltage_code_decode_select, zone34_half_degree_select, zone12_half_degree_select,
        tach4_enhanced_enable, tach3_enhanced_enable, tach2_enhanced_enable, tach1_enhanced_enable};
    wire [7:0] thr_out = {pin7_low_threshold, pin6_low_threshold, pin5_low_threshold, pin4_low_threshold,
        input9_low_threshold, input8_low_threshold, 1'b0, cpu_code_pins_low_threshold};

    mon_cfg_regs dut (.core_clk, .rst_n, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_wr_hit,
        .reg_rd_data, .reg_rd_valid, .reg_rd_hit, .cycle_start, .settings_pending, .tach1_enhanced_enable,
        .tach2_enhanced_enable, .tach3_enhanced_enable, .tach4_enhanced_enable, .zone12_half_degree_select,
        .zone34_half_degree_select, .voltage_code_decode_select, .cpu_code_pins_low_threshold,
        .input8_low_threshold, .input9_low_threshold, .pin4_low_threshold, .pin5_low_threshold,
        .pin6_low_threshold, .pin7_low_threshold, .cpu_code_pins, .code_value, .code_level, .code_in_range,
        .tach_count, .tach_limit, .tach_done, .tach_err_clear, .tach_err);

    always #5 core_clk = ~core_clk;

    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xorshift

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        $display("Mismatches %0d, comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic hit;
        hit = (a == `ADDR_CTRL_TWO) || (a == `ADDR_THR_SEL);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wr_en <= 1'b1;
        reg_wr_data <= d;
        #1 check(16'(reg_wr_hit), 16'(hit));
        @(posedge core_clk);
        reg_wr_en <= 1'b0;
        if (a == `ADDR_CTRL_TWO) m_ctrl = d;
        if (a == `ADDR_THR_SEL) m_thr = d & `THR_SEL_WR_MASK;
        if (hit) m_pend = 1'b1;
        #1 check(16'({settings_pending, ctrl_out}), 16'({m_pend, a_ctrl}));
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge core_clk);
        reg_rd_en <= 1'b0;
        #1 check(16'({reg_rd_valid, reg_rd_hit, reg_rd_data}),
            16'({1'b1, (a == `ADDR_CTRL_TWO) || (a == `ADDR_THR_SEL), exp}));
    endtask : rd

    task automatic apply();
        @(posedge core_clk);
        cycle_start <= 1'b1;
        @(posedge core_clk);
        cycle_start <= 1'b0;
        a_ctrl = m_ctrl;
        a_thr = m_thr;
        m_pend = 1'b0;
        repeat (2) @(posedge core_clk);
        #1 check(16'({ctrl_out, settings_pending}), 16'({a_ctrl, 1'b0}));
        check(16'(thr_out), 16'({a_thr[7:4], a_thr[3:2] & {2{a_ctrl[7:6] == 2'h0}}, 1'b0, a_thr[0]}));
    endtask : apply

    task automatic code(input logic [7:0] p);
        logic [7:0] v;
        int lvl;
        int flo;
        @(posedge core_clk);
        cpu_code_pins <= p;
        @(posedge core_clk);
        case (a_ctrl[7:6])
            2'h0: v = {2'b00, p[5:0]};
            2'h3: v = {p[7:1], 1'b0};
            default: v = {1'b0, p[6:0]};
        endcase
        lvl = 256 - ((a_ctrl[7:6] == 2'h0) ? 2 * v : v);
        flo = (a_ctrl[7:6] == 2'h0) ? 134 : ((a_ctrl[7:6] == 2'h3) ? 6 : 133);
        #1 check(16'(code_value), 16'(v));
        check(16'({code_in_range, code_level}), 16'({lvl >= flo, 9'(lvl)}));
    endtask : code

    task automatic tach(input int i, input tach_word_t cnt, input tach_word_t lim, input logic clr);
        @(posedge core_clk);
        tach_done[i] <= 1'b1;
        tach_count[i] <= cnt;
        tach_limit[i] <= lim;
        tach_err_clear[i] <= clr;
        @(posedge core_clk);
        tach_done[i] <= 1'b0;
        tach_err_clear[i] <= 1'b0;
        if (cnt > lim && lim != `TACH_NO_LIMIT) m_err[i] = 1'b1;
        else if (clr) m_err[i] = 1'b0;
        #1 check(16'(tach_err), 16'(m_err));
    endtask : tach

    initial begin
        logic [31:0] r;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(`ADDR_CTRL_TWO, `CTRL_TWO_RESET);
        rd(`ADDR_THR_SEL, `THR_SEL_RESET);
        check(16'({ctrl_out, thr_out}), 16'h0000);
        for (int m = 0; m < 4; m++) begin
            r = xorshift();
            // Host side: no PWM runs at 22.5 kHz here, and tach binding lives outside the block
            wr(`ADDR_CTRL_TWO, {m[1:0], r[5:0]});
            wr(`ADDR_THR_SEL, r[15:8] | 8'h0E);
            rd(`ADDR_CTRL_TWO, m_ctrl);
            rd(`ADDR_THR_SEL, m_thr);
            apply();
            code(8'hFF);
            code(8'h00);
            repeat (4) code(8'(xorshift() >> 24));
        end
        wr(8'hBC, 8'hFF);
        wr(8'hBF, 8'hAA);
        rd(8'hBC, 8'h00);
        rd(`ADDR_CTRL_TWO, m_ctrl);
        for (int i = 0; i < `NUM_TACH; i++) begin
            r = xorshift();
            tach(i, {1'b1, r[12:0]}, {1'b0, r[25:13]}, 1'b0);
            tach(i, 14'h0005, 14'h0005, 1'b1);
            tach(i, `TACH_NO_LIMIT, `TACH_NO_LIMIT, 1'b0);
            tach(i, 14'h00C8, 14'h0064, 1'b1);
            tach(i, 14'h0000, 14'h0064, 1'b1);
        end
        wrap_up();
    end

    // Whole run needs about 150 cycles; this leaves a wide margin
    initial begin
        #200000;
        errors++;
        wrap_up();
    end
endmodule : vid_mode_tach_config_regs_test
